// ---- shared/icd_consts.svh ----
// Behaviour
// - enable bit 0 turns preview channel on
// - enable bit 1 turns codec channel on
// - disable bit 0 requests preview channel off
// - disable bit 1 requests codec channel off
// - state register: bit0 preview, bit1 codec
// - preview image base word aligned, bits 31:2
// - codec image base word aligned, bits 31:2
// - preview descriptor address in bits 31:2
// - codec descriptor address in bits 31:2
// - preview control bit 0 enables descriptor fetch
// - preview control bit 1 enables descriptor writeback
// - preview control bit 2 suppresses done flag
// - codec bits 0,1 enable fetch and writeback
// - codec control bit 2 suppresses done flag
// - writeback sets descriptor done bit 3 in memory
// - done bit never set in register copy
// - key plus bit 0 set enables protection
// - key plus bit 0 clear disables protection
// - wrong key leaves protection unchanged
// - violation status records kinds, clears on read
// - no state change while sync in progress
// - transfer completion sets done flag, read clears
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH
`define ICD_OFS_CH_ENABLE 12'h000
`define ICD_OFS_CH_DISABLE 12'h004
`define ICD_OFS_CH_STATE 12'h008
`define ICD_OFS_P_BASE 12'h00c
`define ICD_OFS_P_CTRL 12'h010
`define ICD_OFS_PREVIEW_DESCRIPTOR_ADDRESS 12'h014
`define ICD_OFS_C_BASE 12'h018
`define ICD_OFS_C_CTRL 12'h01c
`define ICD_OFS_CODEC_DESCRIPTOR_ADDRESS 12'h020
`define ICD_OFS_PROT_CTRL 12'h024
`define ICD_OFS_PROT_STAT 12'h028
`define ICD_OFS_CAP_STAT 12'h02c
`define ICD_KEY 24'h495349
`define ICD_CTRL_FETCH 0
`define ICD_CTRL_WB 1
`define ICD_CTRL_SUPPRESS 2
`define ICD_CTRL_DONE 3
`define ICD_CAP_P_DONE 16
`define ICD_CAP_C_DONE 17
`define ICD_CAP_SIP 19
`define ICD_CAP_P_OVR 24
`define ICD_CAP_C_OVR 25
`define ICD_VS_BLOCKED 4'h1
`define ICD_VS_SWRST 4'h2
`define ICD_SYNC_CYCLES 4'h4
`define ICD_RESET_WORD 32'h0000_0000
`endif

// ---- shared/icd_pkg.sv ----
package icd_pkg;
    typedef enum logic [1:0] {
        icd_idle,
        icd_fetch,
        icd_move,
        icd_write_back
    } icd_chan_state_type;
endpackage : icd_pkg

// ---- rtl/icd_sync_gate.sv ----
`include "icd_consts.svh"
// models the capture-domain crossing: request lands after a fixed delay
module icd_sync_gate import icd_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic on_req,
    input wire logic off_req,
    output logic state,
    output logic busy
);
    logic [3:0] count;
    logic target;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            count <= 4'h0;
            target <= 1'b0;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end else if (on_req || off_req) begin
            // enable wins if both land together
            target <= on_req;
            count <= `ICD_SYNC_CYCLES;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= 1'b0;
        end else if (count == 4'h1) begin
            state <= target;
        end
    end

    assign busy = (count != 4'h0);
endmodule : icd_sync_gate

// ---- rtl/icd_chan.sv ----
`include "icd_consts.svh"
// one channel sequencer: fetch descriptor, run, write back done
module icd_chan import icd_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic active,
    input wire logic [31:0] ctrl,
    input wire logic [31:0] dscr,
    input wire logic frame_done,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic finished
);
    icd_chan_state_type st;
    logic [31:0] desc_word;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st <= icd_idle;
            desc_word <= `ICD_RESET_WORD;
            finished <= 1'b0;
        end else begin
            finished <= 1'b0;
            case (st)
                icd_idle: begin
                    if (active) begin
                        st <= ctrl[`ICD_CTRL_FETCH] ? icd_fetch : icd_move;
                        desc_word <= ctrl;
                    end
                end
                icd_fetch: begin
                    if (mem_ack) begin
                        desc_word <= mem_rdata;
                        st <= icd_move;
                    end
                end
                icd_move: begin
                    if (frame_done) begin
                        // suppress bit is inverted sense
                        finished <= !ctrl[`ICD_CTRL_SUPPRESS];
                        st <= ctrl[`ICD_CTRL_WB] ? icd_write_back : icd_idle;
                    end
                end
                icd_write_back: begin
                    if (mem_ack) begin
                        st <= icd_idle;
                    end
                end
                default: st <= icd_idle;
            endcase
        end
    end

    always_comb begin
        mem_req = (st == icd_fetch) || (st == icd_write_back);
        mem_write = (st == icd_write_back);
        mem_addr = {dscr[31:2], 2'b00};
        mem_wdata = desc_word;
        mem_wdata[`ICD_CTRL_DONE] = 1'b1;
    end
endmodule : icd_chan

// ---- rtl/icd_dma_regs.sv ----
// Chosen here: the register addresses and the APB slave port.
`include "icd_consts.svh"
module icd_dma_regs import icd_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic preview_frame_done,
    input wire logic codec_frame_done,
    input wire logic preview_overflow,
    input wire logic codec_overflow,
    input wire logic soft_reset_event,
    output logic preview_mem_req,
    output logic preview_mem_write,
    output logic [31:0] preview_mem_addr,
    output logic [31:0] preview_mem_wdata,
    input wire logic preview_mem_ack,
    input wire logic [31:0] preview_mem_rdata,
    output logic codec_mem_req,
    output logic codec_mem_write,
    output logic [31:0] codec_mem_addr,
    output logic [31:0] codec_mem_wdata,
    input wire logic codec_mem_ack,
    input wire logic [31:0] codec_mem_rdata,
    output logic [31:0] preview_image_base_out,
    output logic [31:0] codec_image_base_out,
    output logic preview_channel_state,
    output logic codec_channel_state
);
    logic [31:0] preview_image_base;
    logic [31:0] preview_channel_control;
    logic [31:0] preview_descriptor_pointer;
    logic [31:0] codec_image_base;
    logic [31:0] codec_channel_control;
    logic [31:0] codec_descriptor_pointer;
    logic write_protect;
    logic [3:0] violation_kind;
    logic [3:0] violation_source;
    logic preview_transfer_finished;
    logic codec_transfer_finished;
    logic p_ovr_flag;
    logic c_ovr_flag;
    logic p_busy;
    logic c_busy;
    logic p_fin;
    logic c_fin;
    logic sync_in_progress;
    logic wr;
    logic rd;
    logic mapped;
    logic cfg_hit;
    logic [3:0] cfg_src;
    logic preview_channel_on;
    logic codec_channel_on;
    logic preview_channel_off;
    logic codec_channel_off;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction : hit

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_comb begin
        mapped = 1'b1;
        cfg_hit = 1'b0;
        cfg_src = 4'h0;
        if (hit(paddr, `ICD_OFS_P_BASE)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h1;
        end else if (hit(paddr, `ICD_OFS_P_CTRL)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h2;
        end else if (hit(paddr, `ICD_OFS_PREVIEW_DESCRIPTOR_ADDRESS)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h3;
        end else if (hit(paddr, `ICD_OFS_C_BASE)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h4;
        end else if (hit(paddr, `ICD_OFS_C_CTRL)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h5;
        end else if (hit(paddr, `ICD_OFS_CODEC_DESCRIPTOR_ADDRESS)) begin
            cfg_hit = 1'b1;
            cfg_src = 4'h6;
        end else if (!(hit(paddr, `ICD_OFS_CH_ENABLE) || hit(paddr, `ICD_OFS_CH_DISABLE)
                || hit(paddr, `ICD_OFS_CH_STATE) || hit(paddr, `ICD_OFS_PROT_CTRL)
                || hit(paddr, `ICD_OFS_PROT_STAT) || hit(paddr, `ICD_OFS_CAP_STAT))) begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel && penable && !mapped;

    // state commands are dropped while a crossing is still running
    assign sync_in_progress = p_busy || c_busy;
    always_comb begin
        preview_channel_on = wr && hit(paddr, `ICD_OFS_CH_ENABLE) && pwdata[0]
            && !sync_in_progress;
        codec_channel_on = wr && hit(paddr, `ICD_OFS_CH_ENABLE) && pwdata[1]
            && !sync_in_progress;
        preview_channel_off = wr && hit(paddr, `ICD_OFS_CH_DISABLE) && pwdata[0]
            && !sync_in_progress;
        codec_channel_off = wr && hit(paddr, `ICD_OFS_CH_DISABLE) && pwdata[1]
            && !sync_in_progress;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            preview_image_base <= `ICD_RESET_WORD;
            preview_channel_control <= `ICD_RESET_WORD;
            preview_descriptor_pointer <= `ICD_RESET_WORD;
            codec_image_base <= `ICD_RESET_WORD;
            codec_channel_control <= `ICD_RESET_WORD;
            codec_descriptor_pointer <= `ICD_RESET_WORD;
        end else if (wr && cfg_hit && !write_protect) begin
            if (cfg_src == 4'h1) begin
                preview_image_base <= {pwdata[31:2], 2'b00};
            end else if (cfg_src == 4'h2) begin
                preview_channel_control <= {29'h0, pwdata[2:0]};
            end else if (cfg_src == 4'h3) begin
                preview_descriptor_pointer <= {pwdata[31:2], 2'b00};
            end else if (cfg_src == 4'h4) begin
                codec_image_base <= {pwdata[31:2], 2'b00};
            end else if (cfg_src == 4'h5) begin
                codec_channel_control <= {29'h0, pwdata[2:0]};
            end else begin
                codec_descriptor_pointer <= {pwdata[31:2], 2'b00};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            write_protect <= 1'b0;
        end else if (wr && hit(paddr, `ICD_OFS_PROT_CTRL) && pwdata[31:8] == `ICD_KEY) begin
            write_protect <= pwdata[0];
        end
    end

    // new events win over the clear of a read in the same cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            violation_kind <= 4'h0;
            violation_source <= 4'h0;
        end else begin
            if (rd && hit(paddr, `ICD_OFS_PROT_STAT)) begin
                violation_kind <= 4'h0;
                violation_source <= 4'h0;
            end
            if (wr && cfg_hit && write_protect) begin
                violation_kind[0] <= 1'b1;
                violation_source <= cfg_src;
            end
            if (soft_reset_event && write_protect) begin
                violation_kind[1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            preview_transfer_finished <= 1'b0;
            codec_transfer_finished <= 1'b0;
            p_ovr_flag <= 1'b0;
            c_ovr_flag <= 1'b0;
        end else begin
            if (rd && hit(paddr, `ICD_OFS_CAP_STAT)) begin
                preview_transfer_finished <= 1'b0;
                codec_transfer_finished <= 1'b0;
                p_ovr_flag <= 1'b0;
                c_ovr_flag <= 1'b0;
            end
            if (p_fin) begin
                preview_transfer_finished <= 1'b1;
            end
            if (c_fin) begin
                codec_transfer_finished <= 1'b1;
            end
            if (preview_overflow) begin
                p_ovr_flag <= 1'b1;
            end
            if (codec_overflow) begin
                c_ovr_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prdata <= `ICD_RESET_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= `ICD_RESET_WORD;
            if (hit(paddr, `ICD_OFS_CH_STATE)) begin
                prdata <= {30'h0, codec_channel_state, preview_channel_state};
            end else if (hit(paddr, `ICD_OFS_P_BASE)) begin
                prdata <= preview_image_base;
            end else if (hit(paddr, `ICD_OFS_P_CTRL)) begin
                prdata <= preview_channel_control;
            end else if (hit(paddr, `ICD_OFS_PREVIEW_DESCRIPTOR_ADDRESS)) begin
                prdata <= preview_descriptor_pointer;
            end else if (hit(paddr, `ICD_OFS_C_BASE)) begin
                prdata <= codec_image_base;
            end else if (hit(paddr, `ICD_OFS_C_CTRL)) begin
                prdata <= codec_channel_control;
            end else if (hit(paddr, `ICD_OFS_CODEC_DESCRIPTOR_ADDRESS)) begin
                prdata <= codec_descriptor_pointer;
            end else if (hit(paddr, `ICD_OFS_PROT_CTRL)) begin
                prdata <= {31'h0, write_protect};
            end else if (hit(paddr, `ICD_OFS_PROT_STAT)) begin
                prdata <= {8'h0, 12'h0, violation_source, 4'h0, violation_kind};
            end else if (hit(paddr, `ICD_OFS_CAP_STAT)) begin
                prdata <= {6'h0, c_ovr_flag, p_ovr_flag, 4'h0, sync_in_progress, 1'b0,
                    codec_transfer_finished, preview_transfer_finished, 16'h0};
            end
        end
    end

    icd_sync_gate u_p_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .on_req(preview_channel_on),
        .off_req(preview_channel_off),
        .state(preview_channel_state),
        .busy(p_busy)
    );

    icd_sync_gate u_c_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .on_req(codec_channel_on),
        .off_req(codec_channel_off),
        .state(codec_channel_state),
        .busy(c_busy)
    );

    icd_chan u_p_chan (
        .core_clk(core_clk),
        .nrst(nrst),
        .active(preview_channel_state),
        .ctrl(preview_channel_control),
        .dscr(preview_descriptor_pointer),
        .frame_done(preview_frame_done),
        .mem_req(preview_mem_req),
        .mem_write(preview_mem_write),
        .mem_addr(preview_mem_addr),
        .mem_wdata(preview_mem_wdata),
        .mem_ack(preview_mem_ack),
        .mem_rdata(preview_mem_rdata),
        .finished(p_fin)
    );

    icd_chan u_c_chan (
        .core_clk(core_clk),
        .nrst(nrst),
        .active(codec_channel_state),
        .ctrl(codec_channel_control),
        .dscr(codec_descriptor_pointer),
        .frame_done(codec_frame_done),
        .mem_req(codec_mem_req),
        .mem_write(codec_mem_write),
        .mem_addr(codec_mem_addr),
        .mem_wdata(codec_mem_wdata),
        .mem_ack(codec_mem_ack),
        .mem_rdata(codec_mem_rdata),
        .finished(c_fin)
    );

    assign preview_image_base_out = preview_image_base;
    assign codec_image_base_out = codec_image_base;
endmodule : icd_dma_regs

// ---- tb/icd_mem_model.sv ----
`include "icd_consts.svh"
// system memory behind the bus master, one port per channel
module icd_mem_model import icd_pkg::*; #(
    parameter logic [31:0] DSCR_WORD = 32'h0000_0000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [31:0] last_wdata,
    output logic [31:0] last_addr,
    output int wr_count,
    output int rd_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lag;
    // read bus toggles between answers to expose stale sampling
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            {mem_ack, lag, wr_count, rd_count, last_wdata, last_addr} <= '0;
            mem_rdata <= 32'hffff_ffff;
        end else if (mem_req && !mem_ack && lag < (slow ? 3'h5 : 3'h0)) begin
            lag <= lag + 3'h1;
        end else if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            lag <= 3'h0;
            last_addr <= mem_addr;
            if (mem_write) begin
                wr_count <= wr_count + 1;
                last_wdata <= mem_wdata;
            end else begin
                rd_count <= rd_count + 1;
                mem_rdata <= DSCR_WORD;
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : icd_mem_model

// ---- tb/icd_dma_regs_assertions.sv ----
`include "icd_consts.svh"
module icd_dma_regs_assertions import icd_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic preview_mem_req,
    input wire logic preview_mem_ack,
    input wire logic preview_mem_write,
    input wire logic [31:0] preview_mem_addr,
    input wire logic [31:0] preview_mem_wdata,
    input wire logic codec_mem_req,
    input wire logic [31:0] codec_mem_addr,
    input wire logic [31:0] preview_image_base_out,
    input wire logic [31:0] codec_image_base_out,
    input wire logic preview_channel_state,
    input wire logic codec_channel_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] p_on_age, c_on_age, p_off_age, c_off_age;
    logic wr_on, wr_off;
    assign wr_on = psel && penable && pwrite && paddr == `ICD_OFS_CH_ENABLE;
    assign wr_off = psel && penable && pwrite && paddr == `ICD_OFS_CH_DISABLE;
    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : (a == 4'hf ? a : a + 4'h1);
    endfunction : age
    // saturating ages: a stale command excuses nothing
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            {p_on_age, c_on_age, p_off_age, c_off_age} <= '1;
        end else begin
            p_on_age <= age(wr_on && pwdata[0], p_on_age);
            c_on_age <= age(wr_on && pwdata[1], c_on_age);
            p_off_age <= age(wr_off && pwdata[0], p_off_age);
            c_off_age <= age(wr_off && pwdata[1], c_off_age);
        end
    end
    default clocking ck @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    a_preview_on_cause: assert property (
        $rose(preview_channel_state) |-> p_on_age <= 4'h8) else $error("preview on uncaused");
    a_codec_on_cause: assert property (
        $rose(codec_channel_state) |-> c_on_age <= 4'h8) else $error("codec on uncaused");
    a_preview_off_cause: assert property (
        $fell(preview_channel_state) |-> p_off_age <= 4'h8) else $error("preview off uncaused");
    a_codec_off_cause: assert property (
        $fell(codec_channel_state) |-> c_off_age <= 4'h8) else $error("codec off uncaused");
    a_req_held_addr: assert property (
        preview_mem_req && !preview_mem_ack |=> preview_mem_req && $stable(preview_mem_addr))
        else $error("request dropped");
    a_wb_done_word: assert property (
        preview_mem_req && preview_mem_write |-> preview_mem_wdata[`ICD_CTRL_DONE])
        else $error("done bit missing");
    a_desc_word_aligned: assert property (
        (preview_mem_req || codec_mem_req) |->
        preview_mem_addr[1:0] == 2'b00 && codec_mem_addr[1:0] == 2'b00)
        else $error("descriptor unaligned");
    a_base_word_aligned: assert property (
        preview_image_base_out[1:0] == 2'b00 && codec_image_base_out[1:0] == 2'b00)
        else $error("base unaligned");
    a_reset_clears_all: assert property (disable iff (1'b0)
        !nrst |=> !preview_channel_state && !codec_channel_state && !preview_mem_req
        && preview_image_base_out == 32'h0) else $error("reset incomplete");
endmodule : icd_dma_regs_assertions

// ---- tb/tb_icd_dma_regs.sv ----
`include "icd_consts.svh"
module tb_icd_dma_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, p_addr, c_addr, p_wdata, c_wdata, p_rdata, c_rdata;
    logic [31:0] p_base, c_base, p_last, c_last, p_laddr, c_laddr;
    logic p_fd, c_fd, soft_rst, p_req, p_wr, p_ack, c_req, c_wr, c_ack, p_state, c_state;
    int p_wcnt, p_rcnt, c_wcnt, c_rcnt;
    int err_total = 0, checks_done = 0;
    icd_dma_regs u_icd_dma_regs (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .preview_frame_done(p_fd), .codec_frame_done(c_fd),
        .preview_overflow(1'b0), .codec_overflow(1'b0), .soft_reset_event(soft_rst),
        .preview_mem_req(p_req), .preview_mem_write(p_wr), .preview_mem_addr(p_addr),
        .preview_mem_wdata(p_wdata), .preview_mem_ack(p_ack), .preview_mem_rdata(p_rdata),
        .codec_mem_req(c_req), .codec_mem_write(c_wr), .codec_mem_addr(c_addr),
        .codec_mem_wdata(c_wdata), .codec_mem_ack(c_ack), .codec_mem_rdata(c_rdata),
        .preview_image_base_out(p_base), .codec_image_base_out(c_base),
        .preview_channel_state(p_state), .codec_channel_state(c_state));
    icd_mem_model #(.DSCR_WORD(32'h3)) u_icd_mem_model_p (.core_clk(core_clk), .nrst(nrst),
        .slow(1'b1), .mem_req(p_req), .mem_write(p_wr), .mem_addr(p_addr), .mem_wdata(p_wdata),
        .mem_ack(p_ack), .mem_rdata(p_rdata), .last_wdata(p_last), .last_addr(p_laddr),
        .wr_count(p_wcnt), .rd_count(p_rcnt));
    icd_mem_model u_icd_mem_model_c (.core_clk(core_clk), .nrst(nrst), .slow(1'b0),
        .mem_req(c_req), .mem_write(c_wr), .mem_addr(c_addr), .mem_wdata(c_wdata),
        .mem_ack(c_ack), .mem_rdata(c_rdata), .last_wdata(c_last), .last_addr(c_laddr),
        .wr_count(c_wcnt), .rd_count(c_rcnt));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk_word(q & m, x);
    endtask : rd_chk
    // state lags the command; software polls
    task automatic poll(input logic [1:0] x);
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, `ICD_OFS_CH_STATE, 32'h0, q, e);
            if (q[1:0] === x) break;
        end
        chk_word(q, {30'h0, x});
        repeat (6) @(posedge core_clk);
    endtask : poll
    task automatic wait_pos(ref int c);
        for (int i = 0; i < 300 && c == 0; i++) @(posedge core_clk);
        chk_word(32'(c > 0), 32'h1);
    endtask : wait_pos
    task automatic pulse_srst();
        @(posedge core_clk);
        soft_rst <= 1'b1;
        @(posedge core_clk);
        soft_rst <= 1'b0;
    endtask : pulse_srst
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rd_chk(`ICD_OFS_CH_STATE + 12'(4 * i), '1, 32'h0);
        chk_word({31'h0, p_state | c_state}, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 6; i++) begin
            wr(`ICD_OFS_P_BASE + 12'(4 * i), 32'hffff_ffff);
            rd_chk(`ICD_OFS_P_BASE + 12'(4 * i), '1, (i % 3 == 1) ? 32'h7 : 32'hffff_fffc);
        end
        chk_word(c_base, 32'hffff_fffc);
        chk_word(p_base, 32'hffff_fffc);
        apb(1'b0, 12'h030, 32'h0, q, e);
        chk_word({e, q[30:0]}, 32'h8000_0000);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_prot();
        wr(`ICD_OFS_PROT_CTRL, {`ICD_KEY, 8'h01});
        rd_chk(`ICD_OFS_PROT_CTRL, 32'h1, 32'h1);
        wr(`ICD_OFS_P_BASE, 32'h0000_0100);
        rd_chk(`ICD_OFS_P_BASE, '1, 32'hffff_fffc);
        rd_chk(`ICD_OFS_PROT_STAT, 32'hf, 32'h1);
        rd_chk(`ICD_OFS_PROT_STAT, 32'hf, 32'h0);
        pulse_srst();
        rd_chk(`ICD_OFS_PROT_STAT, 32'hf, 32'h2);
        wr(`ICD_OFS_CODEC_DESCRIPTOR_ADDRESS, 32'h0);
        pulse_srst();
        rd_chk(`ICD_OFS_PROT_STAT, 32'hf, 32'h3);
        wr(`ICD_OFS_PROT_CTRL, {24'h495348, 8'h00});
        rd_chk(`ICD_OFS_PROT_CTRL, 32'h1, 32'h1);
        wr(`ICD_OFS_PROT_CTRL, {`ICD_KEY, 8'h00});
        rd_chk(`ICD_OFS_PROT_CTRL, 32'h1, 32'h0);
        wr(`ICD_OFS_P_BASE, 32'h0000_0100);
        rd_chk(`ICD_OFS_P_BASE, '1, 32'h0000_0100);
        $display("t_prot done");
    endtask : t_prot
    task automatic t_chan();
        wr(`ICD_OFS_CH_ENABLE, 32'h1);
        poll(2'b01);
        wr(`ICD_OFS_CH_ENABLE, 32'h0);
        poll(2'b01);
        wr(`ICD_OFS_CH_ENABLE, 32'h2);
        poll(2'b11);
        wr(`ICD_OFS_CH_DISABLE, 32'h1);
        poll(2'b10);
        wr(`ICD_OFS_CH_DISABLE, 32'h2);
        poll(2'b00);
        wr(`ICD_OFS_CH_ENABLE, 32'h1);
        wr(`ICD_OFS_CH_ENABLE, 32'h2);
        poll(2'b01);
        rd_chk(`ICD_OFS_CH_STATE, 32'h3, 32'h1);
        wr(`ICD_OFS_CH_DISABLE, 32'h1);
        poll(2'b00);
        $display("t_chan done");
    endtask : t_chan
    task automatic t_dma();
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        wr(`ICD_OFS_PREVIEW_DESCRIPTOR_ADDRESS, 32'h0000_1003);
        wr(`ICD_OFS_P_CTRL, 32'h3);
        wr(`ICD_OFS_C_CTRL, 32'h4);
        wr(`ICD_OFS_CH_ENABLE, 32'h3);
        wait_pos(p_rcnt);
        @(posedge core_clk);
        p_fd <= 1'b1;
        c_fd <= 1'b1;
        @(posedge core_clk);
        p_fd <= 1'b0;
        c_fd <= 1'b0;
        wait_pos(p_wcnt);
        chk_word(p_last, 32'h0000_000b);
        chk_word(p_laddr, 32'h0000_1000);
        rd_chk(`ICD_OFS_CAP_STAT, 32'h0003_0000, 32'h0001_0000);
        rd_chk(`ICD_OFS_CAP_STAT, 32'h0003_0000, 32'h0);
        chk_word(32'(c_wcnt + c_rcnt), 32'h0);
        rd_chk(`ICD_OFS_P_CTRL, '1, 32'h3);
        wr(`ICD_OFS_CH_DISABLE, 32'h3);
        poll(2'b00);
        $display("t_dma done");
    endtask : t_dma
    initial begin
        {nrst, psel, penable, pwrite, p_fd, c_fd, soft_rst, paddr, pwdata} = '0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_prot();
        t_chan();
        t_dma();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_icd_dma_regs
bind icd_dma_regs icd_dma_regs_assertions u_icd_dma_regs_assertions (.core_clk(core_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .preview_mem_req(preview_mem_req), .preview_mem_ack(preview_mem_ack),
    .preview_mem_write(preview_mem_write), .preview_mem_addr(preview_mem_addr),
    .preview_mem_wdata(preview_mem_wdata), .codec_mem_req(codec_mem_req),
    .codec_mem_addr(codec_mem_addr), .preview_image_base_out(preview_image_base_out),
    .codec_image_base_out(codec_image_base_out),
    .preview_channel_state(preview_channel_state), .codec_channel_state(codec_channel_state));
